// ==== pkg/uiei_pkg.sv ====
// ****************************************************************
// Constants and carriers for the UART interrupt enable/identify block
// ****************************************************************
`default_nettype none
package uiei_pkg;

  // ****************************************************************
  // Register port geometry and offsets
  // ****************************************************************
  localparam int unsigned ADDR_W          = 4;
  localparam int unsigned DATA_W          = 8;
  localparam logic [3:0]  REG_ENABLE_OFS  = 4'h1;  // Enable, line_control[7]=0
  localparam logic [3:0]  REG_DIVHI_OFS   = 4'h1;  // Divisor high, line_control[7]=1
  localparam logic [3:0]  REG_IDENT_OFS   = 4'h2;  // Identification, line_control[7]=0

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  ENABLE_RST      = 8'h00;
  localparam logic [7:0]  IDENT_RST       = 8'h01;
  localparam logic [7:0]  DIVHI_RST       = 8'h00;
  localparam logic [7:0]  RDATA_RST       = 8'h00;

  // ****************************************************************
  // Enable register field positions
  // ****************************************************************
  localparam int unsigned EN_RXDATA_BIT   = 0;
  localparam int unsigned EN_TXRDY_BIT    = 1;
  localparam int unsigned EN_LINE_BIT     = 2;
  localparam int unsigned EN_MODEM_BIT    = 3;
  localparam int unsigned EN_SLEEP_BIT    = 4;
  localparam int unsigned EN_SWFC_BIT     = 5;
  localparam int unsigned EN_RTSDTR_BIT   = 6;
  localparam int unsigned EN_CTSDSR_BIT   = 7;
  localparam logic [7:0]  EN_LOW_MASK     = 8'h0f;  // Always writable
  localparam logic [7:0]  EN_HIGH_MASK    = 8'hf0;  // Needs enhanced functions

  // ****************************************************************
  // Identification codes, bits 5:0, bit 0 low means pending
  // ****************************************************************
  localparam logic [5:0]  ID_NONE         = 6'h01;
  localparam logic [5:0]  ID_LINE_ERR     = 6'h06;
  localparam logic [5:0]  ID_RX_TIMEOUT   = 6'h0c;
  localparam logic [5:0]  ID_RX_DATA      = 6'h04;
  localparam logic [5:0]  ID_TX_READY     = 6'h02;
  localparam logic [5:0]  ID_MODEM        = 6'h00;
  localparam logic [5:0]  ID_PIN_CHANGE   = 6'h30;
  localparam logic [5:0]  ID_SWFC         = 6'h10;
  localparam logic [5:0]  ID_CTS_RTS      = 6'h20;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Interrupt sources after enable gating, highest priority first
  typedef struct packed {
    logic line_err;
    logic rx_timeout;
    logic rx_data;
    logic tx_ready;
    logic modem;
    logic pin_change;
    logic swfc;
    logic cts_rts;
  } uiei_src_s;

  // Sleep entry and wake conditions from the channel
  typedef struct packed {
    logic modem_quiet;
    logic modem_toggle;
    logic rx_pin;
    logic tx_fifo_empty;
    logic rx_fifo_empty;
    logic tx_fifo_write;
  } uiei_sleep_s;

endpackage
`default_nettype wire

// ==== hdl/uiei_prio_enc.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Priority encoder for the identification code
// ****************************************************************
module uiei_prio_enc
  import uiei_pkg::*;
(
  // Gated sources
  input  wire uiei_src_s  src,
  // Encoded result
  output logic [5:0]      id_code,
  output logic            any_pending
);

  // Only the highest pending source is reported
  function automatic logic [5:0] encode(input uiei_src_s s);
    logic [5:0] c;
    c = ID_NONE;
    if (s.line_err) begin
      c = ID_LINE_ERR;      // Level 1
    end else if (s.rx_timeout) begin
      c = ID_RX_TIMEOUT;    // Level 2
    end else if (s.rx_data) begin
      c = ID_RX_DATA;       // Level 2
    end else if (s.tx_ready) begin
      c = ID_TX_READY;      // Level 3
    end else if (s.modem) begin
      c = ID_MODEM;         // Level 4
    end else if (s.pin_change) begin
      c = ID_PIN_CHANGE;    // Level 5
    end else if (s.swfc) begin
      c = ID_SWFC;          // Level 6
    end else if (s.cts_rts) begin
      c = ID_CTS_RTS;       // Level 7
    end
    return c;
  endfunction

  // Bit 0 of the code reads zero exactly when something is pending
  always_comb begin
    id_code     = encode(src);
    any_pending = |src;
  end

endmodule
`default_nettype wire

// ==== hdl/uiei_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module uiei_top
  import uiei_pkg::*;
(
  // Clock and resets
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              soft_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr_stb,
  input  wire logic              reg_rd_stb,
  input  wire logic [DATA_W-1:0] reg_wdata,
  output logic      [DATA_W-1:0] reg_rdata,
  // Configuration from neighbouring registers
  input  wire logic              divisor_access,
  input  wire logic              enhanced_enable,
  input  wire logic              fifo_enable,
  // Raw events from the channel
  input  wire logic              line_err,
  input  wire logic              rx_timeout,
  input  wire logic              rx_data_avail,
  input  wire logic              tx_holding_empty,
  input  wire logic              tx_space_above_trig,
  input  wire logic              modem_change,
  input  wire logic              pin_change,
  input  wire logic              xoff_detect,
  input  wire logic              xon_detect,
  input  wire logic              special_detect,
  input  wire logic              cts_dsr_inactive,
  input  wire logic              rts_dtr_inactive,
  // Sleep conditions
  input  wire uiei_sleep_s       sleep_cond,
  // Status and clock control
  output logic                   irq_pending,
  output logic      [7:0]        divisor_high,
  output logic                   fifo_mode,
  output logic                   sleep_active,
  output logic                   osc_enable,
  output logic                   uart_clk_enable
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Shared by write and read paths so both agree on the map
  function automatic logic hit_enable(input logic [ADDR_W-1:0] a, input logic dl);
    return (a == REG_ENABLE_OFS) && !dl;
  endfunction

  function automatic logic hit_divhi(input logic [ADDR_W-1:0] a, input logic dl);
    return (a == REG_DIVHI_OFS) && dl;
  endfunction

  function automatic logic hit_ident(input logic [ADDR_W-1:0] a, input logic dl);
    return (a == REG_IDENT_OFS) && !dl;
  endfunction

  typedef enum logic [0:0] {
    AWAKE,
    ASLEEP
  } uiei_sleep_e;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        [7:0] enable_ff;
  logic        [7:0] nxt_enable;
  logic        [7:0] divhi_ff;
  logic        [7:0] nxt_divhi;
  logic              xoff_flag_ff;
  logic              nxt_xoff_flag;
  logic              special_flag_ff;
  logic              nxt_special_flag;
  logic              cts_flag_ff;
  logic              nxt_cts_flag;
  logic              rts_flag_ff;
  logic              nxt_rts_flag;
  uiei_sleep_e       sleep_ff;
  uiei_sleep_e       nxt_sleep;
  logic        [7:0] rdata_ff;
  logic        [7:0] nxt_rdata;
  logic              wr_enable;
  logic              wr_divhi;
  logic              rd_ident;
  logic              tx_ready_raw;
  logic              wake_event;
  logic              sleep_ok;
  logic        [5:0] id_code;
  logic              any_pending;
  logic        [7:0] ident_value;
  uiei_src_s         src;

  // ****************************************************************
  // Access strobes
  // ****************************************************************
  // Writes and reads qualified by address and divisor window
  always_comb begin
    wr_enable = reg_wr_stb && hit_enable(reg_addr, divisor_access);
    wr_divhi  = reg_wr_stb && hit_divhi(reg_addr, divisor_access);
    rd_ident  = reg_rd_stb && hit_ident(reg_addr, divisor_access);
  end

  // ****************************************************************
  // Enable and divisor registers
  // ****************************************************************
  // Upper nibble keeps its value unless enhanced functions are on
  always_comb begin
    nxt_enable = enable_ff;
    nxt_divhi  = divhi_ff;
    if (wr_enable) begin
      nxt_enable = (enable_ff & ~EN_LOW_MASK) | (reg_wdata & EN_LOW_MASK);
      if (enhanced_enable) begin
        nxt_enable = reg_wdata;
      end
    end
    if (soft_rst) begin
      nxt_enable = ENABLE_RST;
    end
    // Divisor is deliberately untouched by the software reset
    if (wr_divhi) begin
      nxt_divhi = reg_wdata;
    end
  end

  // Only the asynchronous power-on reset clears the divisor byte
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      enable_ff <= ENABLE_RST;
      divhi_ff  <= DIVHI_RST;
    end else begin
      enable_ff <= nxt_enable;
      divhi_ff  <= nxt_divhi;
    end
  end

  // ****************************************************************
  // Sticky event flags
  // ****************************************************************
  // Set beats an xon or read clear in the same cycle so no event is lost; software reset beats set
  always_comb begin
    nxt_xoff_flag    = xoff_flag_ff;
    nxt_special_flag = special_flag_ff;
    nxt_cts_flag     = cts_flag_ff;
    nxt_rts_flag     = rts_flag_ff;
    if (xon_detect) begin
      nxt_xoff_flag = 1'b0;
    end
    if (rd_ident) begin
      nxt_special_flag = 1'b0;
    end
    // Level 7 causes drop once software has seen their code
    if (rd_ident && (id_code == ID_CTS_RTS)) begin
      nxt_cts_flag = 1'b0;
      nxt_rts_flag = 1'b0;
    end
    if (xoff_detect) begin
      nxt_xoff_flag = 1'b1;
    end
    if (special_detect) begin
      nxt_special_flag = 1'b1;
    end
    if (cts_dsr_inactive) begin
      nxt_cts_flag = 1'b1;
    end
    if (rts_dtr_inactive) begin
      nxt_rts_flag = 1'b1;
    end
    if (soft_rst) begin
      nxt_xoff_flag    = 1'b0;
      nxt_special_flag = 1'b0;
      nxt_cts_flag     = 1'b0;
      nxt_rts_flag     = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      xoff_flag_ff    <= 1'b0;
      special_flag_ff <= 1'b0;
      cts_flag_ff     <= 1'b0;
      rts_flag_ff     <= 1'b0;
    end else begin
      xoff_flag_ff    <= nxt_xoff_flag;
      special_flag_ff <= nxt_special_flag;
      cts_flag_ff     <= nxt_cts_flag;
      rts_flag_ff     <= nxt_rts_flag;
    end
  end

  // ****************************************************************
  // Source gating
  // ****************************************************************
  // Transmit ready source depends on FIFO mode
  always_comb begin
    tx_ready_raw = fifo_enable ? tx_space_above_trig : tx_holding_empty;
    fifo_mode    = fifo_enable;
  end

  // Enhanced codes use bits 5:4, so they only appear with enhanced functions on
  always_comb begin
    src.line_err   = line_err      && enable_ff[EN_LINE_BIT];
    src.rx_timeout = rx_timeout    && enable_ff[EN_RXDATA_BIT];
    src.rx_data    = rx_data_avail && enable_ff[EN_RXDATA_BIT];
    src.tx_ready   = tx_ready_raw  && enable_ff[EN_TXRDY_BIT];
    src.modem      = modem_change  && enable_ff[EN_MODEM_BIT];
    src.pin_change = pin_change    && enhanced_enable;
    src.swfc       = (xoff_flag_ff || special_flag_ff)
                     && enable_ff[EN_SWFC_BIT] && enhanced_enable;
    src.cts_rts    = ((cts_flag_ff && enable_ff[EN_CTSDSR_BIT])
                     || (rts_flag_ff && enable_ff[EN_RTSDTR_BIT]))
                     && enhanced_enable;
  end

  // ****************************************************************
  // Identification
  // ****************************************************************
  uiei_prio_enc u_prio (
    .src         (src),
    .id_code     (id_code),
    .any_pending (any_pending)
  );

  // FIFO enable is mirrored twice at the top of the byte
  always_comb begin
    ident_value = {fifo_enable, fifo_enable, id_code};
    irq_pending = any_pending;
  end

  // ****************************************************************
  // Sleep control
  // ****************************************************************
  // Wake events are watched on the always-on system clock
  always_comb begin
    sleep_ok   = enable_ff[EN_SLEEP_BIT] && enhanced_enable && !any_pending
                 && sleep_cond.modem_quiet && sleep_cond.rx_pin
                 && sleep_cond.tx_fifo_empty && sleep_cond.rx_fifo_empty;
    wake_event = sleep_cond.modem_toggle || !sleep_cond.rx_pin
                 || sleep_cond.tx_fifo_write;
    nxt_sleep  = sleep_ff;
    unique case (sleep_ff)
      AWAKE: begin
        if (sleep_ok && !wake_event) begin
          nxt_sleep = ASLEEP;
        end
      end
      ASLEEP: begin
        if (wake_event || !enable_ff[EN_SLEEP_BIT] || !enhanced_enable) begin
          nxt_sleep = AWAKE;
        end
      end
    endcase
    if (soft_rst) begin
      nxt_sleep = AWAKE;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_ff <= AWAKE;
    end else begin
      sleep_ff <= nxt_sleep;
    end
  end

  // Clock gates are plain decodes of the registered state
  always_comb begin
    sleep_active    = (sleep_ff == ASLEEP);
    osc_enable      = (sleep_ff == AWAKE);
    uart_clk_enable = (sleep_ff == AWAKE);
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  // Registered read data; unmapped addresses answer zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_stb) begin
      nxt_rdata = RDATA_RST;
      if (hit_enable(reg_addr, divisor_access)) begin
        nxt_rdata = enable_ff;
      end else if (hit_divhi(reg_addr, divisor_access)) begin
        nxt_rdata = divhi_ff;
      end else if (hit_ident(reg_addr, divisor_access)) begin
        nxt_rdata = ident_value;
      end
    end
  end

  // Data holds until the next read strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb begin
    reg_rdata    = rdata_ff;
    divisor_high = divhi_ff;
  end

endmodule
`default_nettype wire

// ==== verification/uiei_chan_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Channel-side event source model
// ****************************************************************
module uiei_chan_model
  import uiei_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Requests from the bench
  input  wire logic [6:0]  lvl_req,
  input  wire logic [4:0]  pls_req,
  input  wire uiei_sleep_s slp_req,
  // Events towards the block
  output logic [6:0]       lvl,
  output logic [4:0]       pls,
  output uiei_sleep_s      slp
);
  // Events leave on a clock edge, as channel logic launches them; a pulse lasts one cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lvl <= 7'h00;
      pls <= 5'h00;
      slp <= '0;
    end else begin
      lvl <= lvl_req;
      pls <= pls_req;
      slp <= slp_req;
    end
  end
endmodule
`default_nettype wire

// ==== verification/uiei_top_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port-level checker
// ****************************************************************
module uiei_chk
  import uiei_pkg::*;
(
  // Clock and resets
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              soft_rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_rd_stb,
  input wire logic              reg_wr_stb,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Configuration and events
  input wire logic              divisor_access,
  input wire logic              enhanced_enable,
  input wire logic              fifo_enable,
  input wire logic              line_err,
  input wire logic              pin_change,
  input wire uiei_sleep_s       sleep_cond,
  // Status
  input wire logic              irq_pending,
  input wire logic [7:0]        divisor_high,
  input wire logic              fifo_mode,
  input wire logic              sleep_active,
  input wire logic              osc_enable,
  input wire logic              uart_clk_enable
);
  logic rd_id;
  logic wake;
  // Decodes only; sampled functions stay inside the properties
  assign rd_id = reg_rd_stb && (reg_addr == REG_IDENT_OFS) && !divisor_access;
  assign wake  = sleep_cond.modem_toggle || !sleep_cond.rx_pin || sleep_cond.tx_fifo_write;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_clk_gate: assert property (
    osc_enable == !sleep_active && uart_clk_enable == !sleep_active)
    else $error("clock enables disagree with sleep state");
  chk_fifo_mode: assert property (fifo_mode == fifo_enable)
    else $error("fifo mode differs from fifo enable");
  chk_id_mirror: assert property (
    rd_id |=> reg_rdata[7:6] == {2{$past(fifo_enable)}})
    else $error("identify upper bits do not mirror fifo enable");
  chk_id_pending: assert property (rd_id |=> reg_rdata[0] == !$past(irq_pending))
    else $error("identify bit 0 disagrees with pending");
  chk_id_line: assert property (
    rd_id ##1 (reg_rdata[5:0] == ID_LINE_ERR) |-> $past(line_err))
    else $error("line code without line error");
  chk_id_pin: assert property (
    rd_id ##1 (reg_rdata[5:0] == ID_PIN_CHANGE) |-> $past(pin_change && enhanced_enable))
    else $error("pin change code without cause");
  chk_rdata_hold: assert property (!reg_rd_stb && !soft_rst |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_sleep_entry: assert property ($rose(sleep_active) |-> $past(
    enhanced_enable && !irq_pending && sleep_cond.modem_quiet && !wake
    && sleep_cond.tx_fifo_empty && sleep_cond.rx_fifo_empty))
    else $error("sleep entered with a condition missing");
  chk_sleep_wake: assert property (sleep_active && wake |=> !sleep_active)
    else $error("wake event did not end sleep");
  chk_divhi_keep: assert property (
    soft_rst && !reg_wr_stb |=> divisor_high == $past(divisor_high))
    else $error("software reset changed divisor high");
endmodule
bind uiei_top uiei_chk u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
  .reg_rd_stb(reg_rd_stb), .reg_wr_stb(reg_wr_stb), .reg_rdata(reg_rdata),
  .divisor_access(divisor_access), .enhanced_enable(enhanced_enable),
  .fifo_enable(fifo_enable), .line_err(line_err), .pin_change(pin_change),
  .sleep_cond(sleep_cond), .irq_pending(irq_pending), .divisor_high(divisor_high),
  .fifo_mode(fifo_mode), .sleep_active(sleep_active), .osc_enable(osc_enable),
  .uart_clk_enable(uart_clk_enable));
`default_nettype wire

// ==== verification/uiei_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench
// ****************************************************************
module uiei_top_tb
  import uiei_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              soft_rst = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic              reg_wr_stb = 1'b0;
  logic              reg_rd_stb = 1'b0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic              dl = 1'b0;
  logic              enh = 1'b0;
  logic              fe = 1'b0;
  logic [6:0]        lvl_req = '0;
  logic [4:0]        pls_req = '0;
  uiei_sleep_s       slp_req = '0;
  logic [6:0]        lvl;
  logic [4:0]        pls;
  uiei_sleep_s       slp;
  logic [7:0]        divisor_high;
  logic              irq_pending, fifo_mode, sleep_active, osc_enable, uart_clk_enable;
  logic [7:0]        d, en, x;
  int                i;
  int                n_fail = 0;
  int                total_checks = 0;
  // Flag tests: enable value, pulse index, expected code
  logic [7:0]        p_en [4] = '{8'h20, 8'h20, 8'h80, 8'h40};
  int                p_idx [4] = '{4, 2, 1, 0};
  logic [7:0]        p_id [4] = '{8'h10, 8'h10, 8'h20, 8'h20};
  uiei_sleep_s       w_req [3] = '{6'h26, 6'h3e, 6'h2f};
  // Clock, 5 ns period
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Far side and block under test
  uiei_chan_model u_chan (.clk_sys(clk_sys), .sys_rst(sys_rst), .lvl_req(lvl_req),
    .pls_req(pls_req), .slp_req(slp_req), .lvl(lvl), .pls(pls), .slp(slp));
  uiei_top u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst), .reg_addr(reg_addr),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .divisor_access(dl), .enhanced_enable(enh), .fifo_enable(fe),
    .line_err(lvl[6]), .rx_timeout(lvl[5]), .rx_data_avail(lvl[4]),
    .tx_holding_empty(lvl[3]), .tx_space_above_trig(lvl[2]), .modem_change(lvl[1]),
    .pin_change(lvl[0]), .xoff_detect(pls[4]), .xon_detect(pls[3]),
    .special_detect(pls[2]), .cts_dsr_inactive(pls[1]), .rts_dtr_inactive(pls[0]),
    .sleep_cond(slp), .irq_pending(irq_pending), .divisor_high(divisor_high),
    .fifo_mode(fifo_mode), .sleep_active(sleep_active), .osc_enable(osc_enable),
    .uart_clk_enable(uart_clk_enable));
  // ****************************************************************
  // Tasks and reference
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // Strobes are one cycle wide; the next access waits for a fresh edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    tick(1);
    reg_addr = a;
    reg_wdata = v;
    reg_wr_stb = 1'b1;
    tick(1);
    reg_wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    tick(1);
    reg_addr = a;
    reg_rd_stb = 1'b1;
    tick(1);
    reg_rd_stb = 1'b0;
    v = reg_rdata;
  endtask
  task automatic pulse(input int k);
    tick(1);
    pls_req = 5'h01 << k;
    tick(1);
    pls_req = 5'h00;
  endtask
  // Later lines win, so sources are listed lowest priority first
  function automatic logic [7:0] exp_id(logic [7:0] e8, logic e, logic f, logic [6:0] v);
    logic [5:0] c;
    c = ID_NONE;
    if (e && v[0]) c = ID_PIN_CHANGE;
    if (e8[3] && v[1]) c = ID_MODEM;
    if (e8[1] && (f ? v[2] : v[3])) c = ID_TX_READY;
    if (e8[0] && v[4]) c = ID_RX_DATA;
    if (e8[0] && v[5]) c = ID_RX_TIMEOUT;
    if (e8[2] && v[6]) c = ID_LINE_ERR;
    return {f, f, c};
  endfunction
  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog, about a hundred times the expected run
  initial begin
    #200000;
    n_fail++;
    $display("watchdog expired");
    test_done();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hf8632383));
    tick(4);
    sys_rst = 1'b0;
    rd(REG_IDENT_OFS, d);
    chk("ident reset", d, 8'h01);
    rd(REG_ENABLE_OFS, d);
    chk("enable reset", d, 8'h00);
    $display("test reset done");
    wr(REG_ENABLE_OFS, 8'hff);
    rd(REG_ENABLE_OFS, d);
    chk("enable no enh", d, 8'h0f);
    enh = 1'b1;
    wr(REG_ENABLE_OFS, 8'hef);
    rd(REG_ENABLE_OFS, d);
    chk("enable enh", d, 8'hef);
    enh = 1'b0;
    wr(REG_ENABLE_OFS, 8'h00);
    rd(REG_ENABLE_OFS, d);
    chk("enable kept", d, 8'he0);
    $display("test enable write done");
    // Random enables and sources; first two passes fix enable and sources, enh and fe stay random
    for (i = 0; i < 40; i++) begin
      enh = 1'b1;
      en = (i < 2) ? 8'h0f : 8'($urandom) & 8'hef;
      wr(REG_ENABLE_OFS, en);
      {enh, fe} = 2'($urandom);
      lvl_req = (i < 2) ? (i ? 7'h01 : 7'h7f) : 7'($urandom);
      tick(2);
      rd(REG_IDENT_OFS, d);
      x = exp_id(en, enh, fe, lvl_req);
      chk("ident", d, x);
      chk("pending", {7'h00, irq_pending}, {7'h00, !x[0]});
    end
    {enh, fe, lvl_req} = {1'b1, 1'b0, 7'h00};
    $display("test priority done");
    for (i = 0; i < 4; i++) begin
      wr(REG_ENABLE_OFS, p_en[i]);
      pulse(p_idx[i]);
      rd(REG_IDENT_OFS, d);
      chk("flag ident", d, p_id[i]);
      rd(REG_IDENT_OFS, d);
      chk("after read", d, (i == 0) ? p_id[0] : 8'h01);
      if (i == 0) begin
        pulse(3);
        rd(REG_IDENT_OFS, d);
        chk("after xon", d, 8'h01);
      end
    end
    wr(REG_ENABLE_OFS, 8'h00);
    pulse(1);
    rd(REG_IDENT_OFS, d);
    chk("gated flag", d, 8'h01);
    $display("test flags done");
    dl = 1'b1;
    wr(REG_DIVHI_OFS, 8'h5a);
    rd(REG_DIVHI_OFS, d);
    chk("divisor high", d, 8'h5a);
    dl = 1'b0;
    wr(REG_ENABLE_OFS, 8'h0f);
    soft_rst = 1'b1;
    tick(1);
    soft_rst = 1'b0;
    rd(REG_ENABLE_OFS, d);
    chk("enable soft", d, 8'h00);
    dl = 1'b1;
    rd(REG_DIVHI_OFS, d);
    chk("divisor soft", d, 8'h5a);
    dl = 1'b0;
    rd(4'h7, d);
    chk("unmapped", d, 8'h00);
    $display("test soft reset done");
    // Pending data blocks sleep, clearing it lets the channel sleep
    wr(REG_ENABLE_OFS, 8'h11);
    lvl_req = 7'h10;
    slp_req = 6'h2e;
    tick(4);
    chk("busy awake", {5'h00, sleep_active, osc_enable, uart_clk_enable}, 8'h03);
    lvl_req = 7'h00;
    tick(4);
    chk("asleep", {5'h00, sleep_active, osc_enable, uart_clk_enable}, 8'h04);
    for (i = 0; i < 3; i++) begin
      slp_req = w_req[i];
      tick(1);
      slp_req = 6'h2e;
      tick(1);
      chk("woken", {7'h00, sleep_active}, 8'h00);
      tick(3);
      chk("slept again", {7'h00, sleep_active}, 8'h01);
    end
    // Dropping the sleep enable must also end sleep
    wr(REG_ENABLE_OFS, 8'h01);
    tick(1);
    chk("sleep off", {7'h00, sleep_active}, 8'h00);
    wr(REG_ENABLE_OFS, 8'h11);
    tick(2);
    chk("asleep again", {7'h00, sleep_active}, 8'h01);
    $display("test sleep done");
    // Power-on reset in mid-run wakes the channel and clears the divisor byte
    chk("divisor port", divisor_high, 8'h5a);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    chk("por awake", {5'h00, sleep_active, osc_enable, uart_clk_enable}, 8'h03);
    chk("divisor por", divisor_high, 8'h00);
    dl = 1'b1;
    rd(REG_DIVHI_OFS, d);
    chk("divisor por read", d, 8'h00);
    dl = 1'b0;
    $display("test power-on reset done");
    test_done();
  end
endmodule
`default_nettype wire
